// *** hdl/raster_pkg.sv ***
// Constants, codes and register map of the polygon rasterizer
`default_nettype none
package raster_pkg;
  localparam int CO_W = 12;
  localparam int FR_W = 4;
  localparam int PIX_W = 8;
  localparam int Z_W = 16;
  localparam int W_W = 12;
  localparam int K_W = 24;
  localparam int AT_W = 16;
  localparam int NSAMP = 4;
  localparam int E_W = 28;
  localparam int WIDE = 72;
  localparam int PROV = 2;
  localparam logic [7:0] A_WINDING = 8'h00;
  localparam logic [7:0] A_REJECT = 8'h04;
  localparam logic [7:0] A_ENABLES = 8'h08;
  localparam logic [7:0] A_FACTOR = 8'h0c;
  localparam logic [7:0] A_UNITS = 8'h10;
  localparam logic [7:0] A_ERROR = 8'h14;
  localparam logic [7:0] A_SC_POS = 8'h18;
  localparam logic [7:0] A_SC_SIZE = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [31:0] COUNTER_CLOCKWISE_WINDING = 32'h0000_0000;
  localparam logic [31:0] CLOCKWISE_WINDING = 32'h0000_0001;
  localparam logic [1:0] MODE_FRONT = 2'h1;
  localparam logic [1:0] MODE_BACK = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  localparam int EN_CULL = 0;
  localparam int EN_FILL = 1;
  localparam int EN_MSAA = 2;
  localparam int EN_SCIS = 3;
  localparam int ERR_WIND = 0;
  localparam int ERR_MODE = 1;
  localparam logic [3:0] RST_ENABLES = 4'h0;
  localparam logic [15:0] RST_FACTOR = 16'h0000;
  localparam logic [15:0] RST_UNITS = 16'h0000;
  localparam logic [8:0] RST_SC_SIZE = 9'h100;
  localparam int FACT_FR = 8;
  localparam int MIN_RES = 1;
  localparam logic [15:0] UNIT_MAX = 16'hffff;
  localparam logic [FR_W-1:0] PT_X [NSAMP+1] = '{4'h6, 4'he, 4'h2, 4'ha, 4'h8};
  localparam logic [FR_W-1:0] PT_Y [NSAMP+1] = '{4'h2, 4'h6, 4'ha, 4'he, 4'h8};
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SETUP = 2'b01, ST_SCAN = 2'b11} state_e;
endpackage : raster_pkg
`default_nettype wire

// *** hdl/polygon_rasterizer.sv ***
// Triangle rasterizer: facing, culling, coverage, interpolation, depth offset
`default_nettype none
module polygon_rasterizer (
  input wire logic ref_clk, // Pipeline clock
  input wire logic reset_n, // Sync reset
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic prim_valid, // Triangle offered
  output logic prim_ready, // Ready for a triangle
  input wire logic [raster_pkg::CO_W-1:0] vert_x [3], // Window x, 8.4
  input wire logic [raster_pkg::CO_W-1:0] vert_y [3], // Window y, 8.4
  input wire logic [raster_pkg::Z_W-1:0] vert_z [3], // Depth, 0..1
  input wire logic [raster_pkg::W_W-1:0] vert_w [3], // Clip w
  input wire logic [raster_pkg::AT_W-1:0] vert_attr [3], // Attribute
  input wire logic prim_flat, // Attribute is flat
  input wire logic pixel_owned, // Window owns pixels, async
  output logic frag_valid, // Fragment offered
  input wire logic frag_ready, // Fragment taken
  output logic [raster_pkg::PIX_W-1:0] frag_x, // Pixel x
  output logic [raster_pkg::PIX_W-1:0] frag_y, // Pixel y
  output logic [raster_pkg::Z_W-1:0] frag_z, // Depth
  output logic [raster_pkg::AT_W-1:0] frag_attr, // Attribute
  output logic [raster_pkg::NSAMP-1:0] frag_coverage, // Sample mask
  output logic frag_front // Polygon is front facing
);
  import raster_pkg::*;

  function automatic logic signed [E_W-1:0] edge_fn(
    input logic [CO_W-1:0] xa, ya, xb, yb, px, py);
    logic signed [CO_W:0] dx, dy, qx, qy;
    dx = $signed({1'b0, xb}) - $signed({1'b0, xa});
    dy = $signed({1'b0, yb}) - $signed({1'b0, ya});
    qx = $signed({1'b0, px}) - $signed({1'b0, xa});
    qy = $signed({1'b0, py}) - $signed({1'b0, ya});
    edge_fn = E_W'(dx) * E_W'(qy) - E_W'(dy) * E_W'(qx);
  endfunction : edge_fn

  function automatic logic [Z_W-1:0] clamp_unit(input logic signed [WIDE-1:0] v);
    if (v < 0) begin
      clamp_unit = '0;
    end else if (v > $signed(WIDE'(UNIT_MAX))) begin
      clamp_unit = UNIT_MAX;
    end else begin
      clamp_unit = v[Z_W-1:0];
    end
  endfunction : clamp_unit

  function automatic logic wind_ok(input logic [31:0] d);
    wind_ok = d == CLOCKWISE_WINDING || d == COUNTER_CLOCKWISE_WINDING;
  endfunction : wind_ok

  function automatic logic mode_ok(input logic [31:0] d);
    mode_ok = d[31:2] == '0 && d[1:0] != 2'h0;
  endfunction : mode_ok

  state_e state_r;
  logic cw_r;
  logic [1:0] mode_r;
  logic [3:0] en_r;
  logic signed [15:0] factor_r, units_r;
  logic [1:0] err_r, err_nxt, bad_c;
  logic [PIX_W-1:0] sc_left_r, sc_bot_r;
  logic [8:0] sc_w_r, sc_h_r;
  logic owned_q1, owned_q2;
  logic [CO_W-1:0] vx_r [3];
  logic [CO_W-1:0] vy_r [3];
  logic [Z_W-1:0] vz_r [3];
  logic [W_W-1:0] vw_r [3];
  logic [AT_W-1:0] va_r [3];
  logic flat_r;
  logic signed [E_W-1:0] area2_c;
  logic front_c, keep_c;
  logic [PIX_W-1:0] xmin_c, xmax_c, ymin_c, ymax_c;
  logic [2:0] own_c;
  logic signed [CO_W:0] edx, edy;
  logic signed [WIDE-1:0] dzdx, dzdy, div_c, m_c, offset_c;
  logic front_r, neg_r;
  logic [2:0] own_r;
  logic signed [E_W-1:0] area_r;
  logic signed [WIDE-1:0] off_r;
  logic [K_W-1:0] k_r [3];
  logic [PIX_W-1:0] px_r, py_r, xmin_r, xmax_r, ymax_r;
  logic signed [E_W-1:0] en_pt [NSAMP+1][3];
  logic [NSAMP:0] pt_in;
  logic signed [WIDE-1:0] kp, num_c, den_c, zsum_c;
  logic [AT_W-1:0] attr_c;
  logic [Z_W-1:0] zfrag_c;
  logic [NSAMP-1:0] cov_c;
  logic sc_ok_c, slot_c, step_c, load_c, last_c;

  // Bad codes leave the setting alone and only flag the error
  always_comb begin
    bad_c = '0;
    if (reg_wr && reg_addr == A_WINDING && !wind_ok(reg_wdata)) begin
      bad_c[ERR_WIND] = 1'b1;
    end
    if (reg_wr && reg_addr == A_REJECT && !mode_ok(reg_wdata)) begin
      bad_c[ERR_MODE] = 1'b1;
    end
    err_nxt = err_r & ~((reg_wr && reg_addr == A_ERROR) ? reg_wdata[1:0] : 2'b00);
    err_nxt = err_nxt | bad_c;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cw_r <= 1'b0;
      mode_r <= MODE_BACK;
      en_r <= RST_ENABLES;
      factor_r <= RST_FACTOR;
      units_r <= RST_UNITS;
      err_r <= '0;
      sc_left_r <= '0;
      sc_bot_r <= '0;
      sc_w_r <= RST_SC_SIZE;
      sc_h_r <= RST_SC_SIZE;
    end else begin
      err_r <= err_nxt;
      if (reg_wr) begin
        case (reg_addr)
          A_WINDING: if (wind_ok(reg_wdata)) cw_r <= reg_wdata == CLOCKWISE_WINDING;
          A_REJECT: if (mode_ok(reg_wdata)) mode_r <= reg_wdata[1:0];
          A_ENABLES: en_r <= reg_wdata[3:0];
          A_FACTOR: factor_r <= reg_wdata[15:0];
          A_UNITS: units_r <= reg_wdata[15:0];
          A_SC_POS: begin
            sc_left_r <= reg_wdata[7:0];
            sc_bot_r <= reg_wdata[15:8];
          end
          A_SC_SIZE: begin
            sc_w_r <= reg_wdata[8:0];
            sc_h_r <= reg_wdata[24:16];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        A_WINDING: reg_rdata <= {31'h0, cw_r};
        A_REJECT: reg_rdata <= {30'h0, mode_r};
        A_ENABLES: reg_rdata <= {28'h0, en_r};
        A_FACTOR: reg_rdata <= {16'h0, factor_r};
        A_UNITS: reg_rdata <= {16'h0, units_r};
        A_ERROR: reg_rdata <= {30'h0, err_r};
        A_SC_POS: reg_rdata <= {16'h0, sc_bot_r, sc_left_r};
        A_SC_SIZE: reg_rdata <= {7'h0, sc_h_r, 7'h0, sc_w_r};
        A_STATUS: reg_rdata <= {28'h0, state_r, front_r, prim_ready};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      owned_q1 <= 1'b0;
      owned_q2 <= 1'b0;
    end else begin
      owned_q1 <= pixel_owned;
      owned_q2 <= owned_q1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prim_valid && prim_ready) begin
      vx_r <= vert_x;
      vy_r <= vert_y;
      vz_r <= vert_z;
      vw_r <= vert_w;
      va_r <= vert_attr;
      flat_r <= prim_flat;
    end
  end

  always_comb begin
    area2_c = edge_fn(vx_r[1], vy_r[1], vx_r[2], vy_r[2], vx_r[0], vy_r[0]);
    // winding flip, strict positive is front
    front_c = cw_r ? (area2_c < 0) : (area2_c > 0);
    keep_c = !en_r[EN_CULL] || (front_c ? mode_r == MODE_BACK : mode_r == MODE_FRONT);
    xmin_c = vx_r[0][CO_W-1:FR_W];
    xmax_c = xmin_c;
    ymin_c = vy_r[0][CO_W-1:FR_W];
    ymax_c = ymin_c;
    for (int j = 1; j < 3; j++) begin
      if (vx_r[j][CO_W-1:FR_W] < xmin_c) xmin_c = vx_r[j][CO_W-1:FR_W];
      if (vx_r[j][CO_W-1:FR_W] > xmax_c) xmax_c = vx_r[j][CO_W-1:FR_W];
      if (vy_r[j][CO_W-1:FR_W] < ymin_c) ymin_c = vy_r[j][CO_W-1:FR_W];
      if (vy_r[j][CO_W-1:FR_W] > ymax_c) ymax_c = vy_r[j][CO_W-1:FR_W];
    end
    // each edge owns its zero line in one direction only
    edx = '0;
    edy = '0;
    for (int j = 0; j < 3; j++) begin
      edx = $signed({1'b0, vx_r[(j+2)%3]}) - $signed({1'b0, vx_r[(j+1)%3]});
      edy = $signed({1'b0, vy_r[(j+2)%3]}) - $signed({1'b0, vy_r[(j+1)%3]});
      if (area2_c < 0) begin
        edx = -edx;
        edy = -edy;
      end
      own_c[j] = edy > 0 || (edy == 0 && edx < 0);
    end
    // Plane slopes per whole pixel; coordinates carry four fraction bits
    dzdx = (WIDE'($signed({1'b0, vz_r[1]}) - $signed({1'b0, vz_r[0]}))
      * WIDE'($signed({1'b0, vy_r[2]}) - $signed({1'b0, vy_r[0]}))
      - WIDE'($signed({1'b0, vz_r[2]}) - $signed({1'b0, vz_r[0]}))
      * WIDE'($signed({1'b0, vy_r[1]}) - $signed({1'b0, vy_r[0]}))) <<< FR_W;
    dzdy = (WIDE'($signed({1'b0, vx_r[1]}) - $signed({1'b0, vx_r[0]}))
      * WIDE'($signed({1'b0, vz_r[2]}) - $signed({1'b0, vz_r[0]}))
      - WIDE'($signed({1'b0, vx_r[2]}) - $signed({1'b0, vx_r[0]}))
      * WIDE'($signed({1'b0, vz_r[1]}) - $signed({1'b0, vz_r[0]}))) <<< FR_W;
    div_c = (area2_c == 0) ? WIDE'(1) : WIDE'(area2_c);
    dzdx = dzdx / div_c;
    dzdy = dzdy / div_c;
    if (dzdx < 0) dzdx = -dzdx;
    if (dzdy < 0) dzdy = -dzdy;
    m_c = (dzdx > dzdy) ? dzdx : dzdy;
    // slope term plus units times one depth code
    offset_c = ((m_c * WIDE'(factor_r)) >>> FACT_FR) + WIDE'(units_r) * WIDE'(MIN_RES);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      front_r <= 1'b0;
      neg_r <= 1'b0;
      own_r <= '0;
      area_r <= '0;
      off_r <= '0;
    end else if (state_r == ST_SETUP) begin
      front_r <= front_c;
      neg_r <= area2_c < 0;
      own_r <= own_c;
      area_r <= (area2_c < 0) ? -area2_c : area2_c;
      // offset only when fill offset is enabled
      off_r <= en_r[EN_FILL] ? offset_c : '0;
      for (int j = 0; j < 3; j++) begin
        k_r[j] <= K_W'(vw_r[(j+1)%3]) * K_W'(vw_r[(j+2)%3]);
      end
    end
  end

  // edge tests at each sample and the center
  for (genvar g = 0; g <= NSAMP; g++) begin : g_pt
    logic [2:0] in_e;
    for (genvar j = 0; j < 3; j++) begin : g_edge
      logic signed [E_W-1:0] e;
      assign e = edge_fn(vx_r[(j+1)%3], vy_r[(j+1)%3], vx_r[(j+2)%3], vy_r[(j+2)%3],
        {px_r, PT_X[g]}, {py_r, PT_Y[g]});
      assign en_pt[g][j] = neg_r ? -e : e;
      assign in_e[j] = en_pt[g][j] > 0 || (en_pt[g][j] == 0 && own_r[j]);
    end
    assign pt_in[g] = &in_e;
  end

  // one evaluation at the center serves all samples of the pixel
  always_comb begin
    num_c = '0;
    den_c = '0;
    zsum_c = '0;
    kp = '0;
    for (int j = 0; j < 3; j++) begin
      // weight over w, using w of the other two vertices
      kp = WIDE'(en_pt[NSAMP][j]) * WIDE'($signed({1'b0, k_r[j]}));
      num_c = num_c + kp * WIDE'($signed({1'b0, va_r[j]}));
      den_c = den_c + kp;
      zsum_c = zsum_c + WIDE'(en_pt[NSAMP][j]) * WIDE'($signed({1'b0, vz_r[j]}));
    end
    if (flat_r || den_c == 0) begin
      attr_c = va_r[PROV];
    end else begin
      attr_c = clamp_unit(num_c / den_c);
    end
    zfrag_c = clamp_unit(zsum_c / WIDE'(area_r) + off_r);
  end

  assign cov_c = en_r[EN_MSAA] ? pt_in[NSAMP-1:0] : {NSAMP{pt_in[NSAMP]}};
  assign sc_ok_c = !en_r[EN_SCIS] ||
    ({2'b0, px_r} >= {2'b0, sc_left_r} && {2'b0, px_r} < {2'b0, sc_left_r} + {1'b0, sc_w_r}
    && {2'b0, py_r} >= {2'b0, sc_bot_r} && {2'b0, py_r} < {2'b0, sc_bot_r} + {1'b0, sc_h_r});
  assign slot_c = !frag_valid || frag_ready;
  assign step_c = state_r == ST_SCAN && slot_c;
  // ownership and scissor drop the fragment
  assign load_c = step_c && (|cov_c) && sc_ok_c && owned_q2;
  assign last_c = px_r == xmax_r && py_r == ymax_r;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      prim_ready <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: if (prim_valid && prim_ready) begin
          state_r <= ST_SETUP;
          prim_ready <= 1'b0;
        end
        // culled or empty polygon returns with no fragments
        ST_SETUP: if (area2_c == 0 || !keep_c) begin
          state_r <= ST_IDLE;
          prim_ready <= 1'b1;
        end else begin
          state_r <= ST_SCAN;
        end
        ST_SCAN: if (step_c && last_c) begin
          state_r <= ST_IDLE;
          prim_ready <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Bounding box walk, one pixel per free output slot
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      px_r <= '0;
      py_r <= '0;
      xmin_r <= '0;
      xmax_r <= '0;
      ymax_r <= '0;
    end else if (state_r == ST_SETUP) begin
      px_r <= xmin_c;
      py_r <= ymin_c;
      xmin_r <= xmin_c;
      xmax_r <= xmax_c;
      ymax_r <= ymax_c;
    end else if (step_c) begin
      if (px_r == xmax_r) begin
        px_r <= xmin_r;
        py_r <= py_r + 8'h01;
      end else begin
        px_r <= px_r + 8'h01;
      end
    end
  end

  // fragment handshake holds data until taken
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frag_valid <= 1'b0;
      frag_x <= '0;
      frag_y <= '0;
      frag_z <= '0;
      frag_attr <= '0;
      frag_coverage <= '0;
      frag_front <= 1'b0;
    end else if (slot_c) begin
      frag_valid <= load_c;
      if (load_c) begin
        frag_x <= px_r;
        frag_y <= py_r;
        frag_z <= zfrag_c;
        frag_attr <= attr_c;
        frag_coverage <= cov_c;
        frag_front <= front_r;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_reject;
    state_r == ST_SETUP && !keep_c;
  endsequence
  sequence s_back_idle;
    state_r == ST_IDLE && prim_ready;
  endsequence

  a_cull_drop: assert property (s_reject |=> s_back_idle)
    else $error("culled polygon entered scan");
  a_face_sign: assert property (state_r == ST_SETUP |=>
    front_r == ($past(cw_r) ? $past(area2_c) < 0 : $past(area2_c) > 0))
    else $error("facing does not follow area sign");
  a_bad_winding: assert property (reg_wr && reg_addr == A_WINDING
    && !wind_ok(reg_wdata) |=> err_r[ERR_WIND] && $stable(cw_r))
    else $error("bad winding code not flagged");
  a_bad_mode: assert property (reg_wr && reg_addr == A_REJECT
    && !mode_ok(reg_wdata) |=> err_r[ERR_MODE] && $stable(mode_r))
    else $error("bad cull mode not flagged");
  a_reset_dflt: assert property (@(posedge ref_clk) disable iff (1'b0)
    !reset_n |=> mode_r == MODE_BACK && en_r == 4'h0 && !cw_r && factor_r == 0 && units_r == 0)
    else $error("reset defaults wrong");
  a_frag_hold: assert property (frag_valid && !frag_ready |=>
    frag_valid && $stable(frag_x) && $stable(frag_y) && $stable(frag_z))
    else $error("fragment changed while stalled");
  a_cov_set: assert property (frag_valid |-> frag_coverage != '0)
    else $error("fragment with empty coverage");
  a_single_cov: assert property (load_c && !en_r[EN_MSAA] |=> frag_coverage == 4'hf)
    else $error("single-sample coverage not full");
  a_flat_attr: assert property (load_c && flat_r |=> frag_attr == $past(va_r[PROV]))
    else $error("flat attribute not from provoking vertex");
  a_scissor_in: assert property (load_c && en_r[EN_SCIS] |-> owned_q2
    && {2'b0, px_r} < {2'b0, sc_left_r} + {1'b0, sc_w_r} && px_r >= sc_left_r)
    else $error("fragment outside scissor or not owned");
  a_offset_off: assert property (state_r == ST_SETUP && !en_r[EN_FILL] |=> off_r == 0)
    else $error("offset applied while disabled");
endmodule : polygon_rasterizer
`default_nettype wire

// *** verif/frag_sink.sv ***
// Downstream fragment consumer: stalls, counts, duplicate and hold tracking
`default_nettype none
module frag_sink (
  input wire logic ref_clk, // Pipeline clock
  input wire logic reset_n, // Sync reset
  input wire logic slow, // Accept one cycle in four
  input wire logic clear, // Forget counts and map
  input wire logic frag_valid, // Fragment offered
  output logic frag_ready, // Fragment taken
  input wire logic [raster_pkg::PIX_W-1:0] frag_x, // Pixel x
  input wire logic [raster_pkg::PIX_W-1:0] frag_y, // Pixel y
  input wire logic [raster_pkg::Z_W-1:0] frag_z, // Depth
  input wire logic [raster_pkg::AT_W-1:0] frag_attr, // Attribute
  input wire logic [raster_pkg::NSAMP-1:0] frag_coverage, // Sample mask
  input wire logic frag_front, // Facing
  output logic [15:0] n_frag, // Fragments taken
  output logic [15:0] n_dup, // Pixels taken twice
  output logic [15:0] n_drift, // Offers changed while stalled
  output logic [52:0] last // Last taken {front,cov,attr,z,y,x}
);
  timeunit 1ns;
  timeprecision 1ps;
  import raster_pkg::*;
  logic [1:0] tick_r;
  logic [255:0] map_r;
  logic held_r;
  logic [52:0] prev_r;
  logic [52:0] now;
  assign now = {frag_front, frag_coverage, frag_attr, frag_z, frag_y, frag_x};
  // Stalls are real gaps so the offered fragment must wait
  assign frag_ready = !slow || tick_r == 2'h0;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || clear) begin
      tick_r <= 2'h0;
      map_r <= '0;
      held_r <= 1'b0;
      n_frag <= 16'h0;
      n_dup <= 16'h0;
      n_drift <= 16'h0;
      last <= '0;
    end else begin
      tick_r <= tick_r + 2'h1;
      held_r <= frag_valid && !frag_ready;
      prev_r <= now;
      if (held_r && (frag_valid !== 1'b1 || now !== prev_r)) begin
        n_drift <= n_drift + 16'h1;
      end
      if (frag_valid && frag_ready) begin
        n_frag <= n_frag + 16'h1;
        last <= now;
        if (map_r[{frag_y[3:0], frag_x[3:0]}]) begin
          n_dup <= n_dup + 16'h1;
        end
        map_r[{frag_y[3:0], frag_x[3:0]}] <= 1'b1;
      end
    end
  end
endmodule : frag_sink
`default_nettype wire

// *** verif/polygon_rasterizer_tb.sv ***
// Self-checking bench for the polygon rasterizer
`default_nettype none
module polygon_rasterizer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import raster_pkg::*;
  typedef struct packed {
    logic wind; logic [3:0] en; logic [1:0] mode; logic [15:0] units; logic [15:0] z;
    logic flat; logic [15:0] n; logic front; logic [15:0] ez; logic [3:0] cov;
  } row_s;
  // Triangle T keeps every pixel center off its edges; A and B split a 4x4 square
  localparam logic [35:0] T_X = {12'h000, 12'h03f, 12'h000};
  localparam logic [35:0] T_Y = {12'h000, 12'h000, 12'h040};
  row_s rows [11] = '{
    '{1'b0, 4'h0, MODE_BACK, 16'h0, 16'h4000, 1'b0, 16'h6, 1'b1, 16'h4000, 4'hf},
    '{1'b0, 4'h1, MODE_BACK, 16'h0, 16'h4000, 1'b0, 16'h6, 1'b1, 16'h4000, 4'hf},
    '{1'b0, 4'h1, MODE_FRONT, 16'h0, 16'h4000, 1'b0, 16'h0, 1'b1, 16'h4000, 4'hf},
    '{1'b0, 4'h1, MODE_BOTH, 16'h0, 16'h4000, 1'b0, 16'h0, 1'b1, 16'h4000, 4'hf},
    '{1'b1, 4'h1, MODE_BACK, 16'h0, 16'h4000, 1'b0, 16'h0, 1'b0, 16'h4000, 4'hf},
    '{1'b1, 4'h1, MODE_FRONT, 16'h0, 16'h4000, 1'b0, 16'h6, 1'b0, 16'h4000, 4'hf},
    '{1'b0, 4'h2, MODE_BACK, 16'h5, 16'h4000, 1'b1, 16'h6, 1'b1, 16'h4005, 4'hf},
    '{1'b0, 4'h2, MODE_BACK, 16'h100, 16'hfff0, 1'b0, 16'h6, 1'b1, 16'hffff, 4'hf},
    '{1'b0, 4'h2, MODE_BACK, 16'hff00, 16'h10, 1'b0, 16'h6, 1'b1, 16'h0, 4'hf},
    '{1'b0, 4'h0, MODE_BACK, 16'h100, 16'h4000, 1'b1, 16'h6, 1'b1, 16'h4000, 4'hf},
    '{1'b0, 4'h4, MODE_BACK, 16'h0, 16'h4000, 1'b0, 16'ha, 1'b1, 16'h4000, 4'h5}};
  logic [7:0] rst_addr [8] = '{A_WINDING, A_REJECT, A_ENABLES, A_FACTOR, A_UNITS, A_ERROR,
    A_SC_SIZE, 8'h30};
  logic [31:0] rst_val [8] = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0100_0100, 32'h0};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic prim_valid = 1'b0;
  logic prim_flat = 1'b0;
  logic pixel_owned = 1'b1;
  logic slow = 1'b0;
  logic clear = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  logic prim_ready, frag_valid, frag_ready, frag_front;
  logic [CO_W-1:0] vert_x [3];
  logic [CO_W-1:0] vert_y [3];
  logic [Z_W-1:0] vert_z [3];
  logic [W_W-1:0] vert_w [3];
  logic [AT_W-1:0] vert_attr [3];
  logic [PIX_W-1:0] frag_x, frag_y;
  logic [Z_W-1:0] frag_z;
  logic [AT_W-1:0] frag_attr;
  logic [NSAMP-1:0] frag_coverage;
  logic [15:0] n_frag, n_dup, n_drift;
  logic [52:0] last;
  int n_mismatch = 0;
  int check_count = 0;

  always #20 ref_clk = ~ref_clk;

  polygon_rasterizer u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prim_valid(prim_valid), .prim_ready(prim_ready), .vert_x(vert_x), .vert_y(vert_y),
    .vert_z(vert_z), .vert_w(vert_w), .vert_attr(vert_attr), .prim_flat(prim_flat),
    .pixel_owned(pixel_owned), .frag_valid(frag_valid), .frag_ready(frag_ready),
    .frag_x(frag_x), .frag_y(frag_y), .frag_z(frag_z), .frag_attr(frag_attr),
    .frag_coverage(frag_coverage), .frag_front(frag_front));

  frag_sink u_sink (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .clear(clear),
    .frag_valid(frag_valid), .frag_ready(frag_ready), .frag_x(frag_x), .frag_y(frag_y),
    .frag_z(frag_z), .frag_attr(frag_attr), .frag_coverage(frag_coverage),
    .frag_front(frag_front), .n_frag(n_frag), .n_dup(n_dup), .n_drift(n_drift), .last(last));

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic clear_sink();
    @(posedge ref_clk);
    clear <= 1'b1;
    @(posedge ref_clk);
    clear <= 1'b0;
  endtask : clear_sink

  // Offer one triangle, then wait until the block is idle and drained
  task automatic draw(input logic [35:0] xs, input logic [35:0] ys);
    int k;
    int q;
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      vert_x[i] <= xs[24-12*i +: 12];
      vert_y[i] <= ys[24-12*i +: 12];
    end
    prim_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (prim_ready !== 1'b1 && k < 100);
    prim_valid <= 1'b0;
    q = 0;
    while (q < 4 && k < 2000) begin
      @(posedge ref_clk);
      k++;
      q = (prim_ready === 1'b1 && frag_valid === 1'b0) ? q + 1 : 0;
    end
    if (k >= 2000) check(32'h0, 32'h1);
  endtask : draw

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    vert_x = '{3{12'h0}};
    vert_y = '{3{12'h0}};
    vert_z = '{3{16'h0}};
    vert_w = '{12'h010, 12'h020, 12'h030};
    vert_attr = '{3{16'h0}};
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (rows[r]) begin
      reg_write(A_WINDING, {31'h0, rows[r].wind});
      reg_write(A_REJECT, {30'h0, rows[r].mode});
      reg_write(A_ENABLES, {28'h0, rows[r].en});
      reg_write(A_UNITS, {{16{rows[r].units[15]}}, rows[r].units});
      slow <= r[0];
      prim_flat <= rows[r].flat;
      vert_z <= '{rows[r].z, rows[r].z, rows[r].z};
      if (rows[r].flat) vert_attr <= '{16'h1111, 16'h2222, 16'h3333};
      else vert_attr <= '{3{16'h5a5a}};
      clear_sink();
      draw(T_X, T_Y);
      check(32'(n_frag), 32'(rows[r].n));
      check(32'(n_drift), 32'h0);
      if (rows[r].n != 16'h0) begin
        check(32'(last[52]), 32'(rows[r].front));
        check(32'(last[31:16]), 32'(rows[r].ez));
        check(32'(last[47:32]), rows[r].flat ? 32'h3333 : 32'h5a5a);
        check(32'(last[51:48]), 32'(rows[r].cov));
      end
    end
    // Second reset in mid-run restores every setting
    reset_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    check(32'(prim_ready), 32'h1);
    for (int i = 0; i < 8; i++) begin
      reg_read(rst_addr[i], v);
      check(v, rst_val[i]);
    end
    reg_write(A_WINDING, 32'h2);
    reg_read(A_WINDING, v);
    check(v, 32'h0);
    reg_read(A_ERROR, v);
    check(v, 32'h1);
    reg_write(A_REJECT, 32'h0);
    reg_read(A_REJECT, v);
    check(v, 32'(MODE_BACK));
    reg_read(A_ERROR, v);
    check(v, 32'h3);
    reg_write(A_ERROR, 32'h3);
    reg_read(A_ERROR, v);
    check(v, 32'h0);
    clear_sink();
    draw({12'h000, 12'h040, 12'h000}, {12'h000, 12'h000, 12'h040});
    draw({12'h040, 12'h040, 12'h000}, {12'h000, 12'h040, 12'h040});
    check(32'(n_frag), 32'h10);
    check(32'(n_dup), 32'h0);
    // Depth rises 0x400 per pixel in x; factor 1.0 adds one slope to every pixel, checked at the last pixel
    reg_write(A_FACTOR, 32'h0000_0100);
    reg_write(A_ENABLES, 32'h2);
    vert_z <= '{16'h0000, 16'h1000, 16'h0000};
    clear_sink();
    draw({12'h000, 12'h040, 12'h000}, {12'h000, 12'h000, 12'h040});
    check(32'(n_frag), 32'ha);
    check(32'(last[15:0]), 32'h0300);
    check(32'(last[31:16]), 32'h0600);
    reg_write(A_SC_POS, 32'h0000_0001);
    reg_write(A_SC_SIZE, 32'h0100_0001);
    reg_write(A_ENABLES, 32'h8);
    clear_sink();
    draw(T_X, T_Y);
    check(32'(n_frag), 32'h2);
    check(32'(last[15:0]), 32'h0101);
    pixel_owned <= 1'b0;
    clear_sink();
    draw(T_X, T_Y);
    check(32'(n_frag), 32'h0);
    tally_and_finish();
  end
endmodule : polygon_rasterizer_tb
`default_nettype wire
